// ### verilog/pawd_pkg.sv
// Package for the peripheral access wait decoder: address regions,
// access lengths, fixed register addresses and the control state type.
// Assumes one core clock; the peripheral clock is an enable pulse.
package pawd_pkg;

   localparam int ADDR_W   = 32;
   localparam int CNT_W    = 8;
   localparam int LEN_W    = 4;
   localparam int DIV_W    = 3;
   localparam int NREG     = 14;
   localparam int IDX_W    = 4;

   // Extra cycles for the 16-bit data registers.
   localparam logic [LEN_W-1:0] WIDE16_EXTRA = 4'h2;

   // Length of an access to an address that no region claims.
   localparam logic [LEN_W-1:0] UNMAPPED_LEN = 4'h2;

   localparam logic [ADDR_W-1:0] SER_RX16_ADDR  = 32'h4009_4010;
   localparam logic [ADDR_W-1:0] SER_TX16_ADDR  = 32'h4009_4014;
   localparam logic [ADDR_W-1:0] CMP_DAT16_ADDR = 32'h4009_5018;

   // Port data, port input and pin function select registers.
   localparam logic [ADDR_W-1:0] PORT_RD_LO = 32'h4004_0000;
   localparam logic [ADDR_W-1:0] PORT_RD_HI = 32'h4004_0FFF;

   localparam logic [CNT_W-1:0]  CNT_RESET  = 8'h00;
   localparam logic [DIV_W-1:0]  DIV_RESET  = 3'h0;

   // Lengths: eq_* with equal clocks, fs_* the least count in peripheral
   // clocks with a faster core clock, sy_* adds the synchronising step.
   typedef struct packed {
      logic [ADDR_W-1:0] lo;
      logic [ADDR_W-1:0] hi;
      logic              pclk;
      logic [LEN_W-1:0]  eq_rd;
      logic [LEN_W-1:0]  eq_wr;
      logic [LEN_W-1:0]  fs_rd;
      logic [LEN_W-1:0]  fs_wr;
      logic              sy_rd;
      logic              sy_wr;
   } pawd_region_type;

   typedef struct packed {
      logic              hit;
      logic [IDX_W-1:0]  idx;
      logic              wide16;
      logic              port_rd;
      pawd_region_type   reg_info;
   } pawd_decode_type;

   typedef enum logic [1:0] {ST_IDLE, ST_SYNC, ST_COUNT} pawd_state_type;

   localparam pawd_region_type REGIONS [NREG] = '{
      '{32'h4000_0000, 32'h4001_BFFF, 1'b0,
        4'h2, 4'h2, 4'h2, 4'h2, 1'b0, 1'b0},
      '{32'h4001_E000, 32'h4001_EFFF, 1'b0,
        4'h4, 4'h4, 4'h4, 4'h4, 1'b0, 1'b0},
      '{32'h4004_0000, 32'h4004_1FFF, 1'b1,
        4'h3, 4'h3, 4'h2, 4'h2, 1'b1, 1'b1},
      '{32'h4004_2000, 32'h4005_FFFF, 1'b1,
        4'h3, 4'h3, 4'h2, 4'h2, 1'b1, 1'b1},
      '{32'h4007_4000, 32'h4007_40FF, 1'b1,
        4'h3, 4'h3, 4'h2, 4'h2, 1'b1, 1'b1},
      '{32'h4008_0000, 32'h4008_00FF, 1'b1,
        4'h2, 4'h2, 4'h2, 4'h1, 1'b0, 1'b1},
      '{32'h4008_5F00, 32'h4008_5FFF, 1'b1,
        4'h3, 4'h3, 4'h3, 4'h2, 1'b0, 1'b1},
      '{32'h4009_1000, 32'h4009_10FF, 1'b1,
        4'h2, 4'h2, 4'h1, 4'h1, 1'b1, 1'b1},
      '{32'h4009_1100, 32'h4009_11FF, 1'b1,
        4'h3, 4'h3, 4'h2, 4'h2, 1'b1, 1'b1},
      '{32'h4009_1200, 32'h4009_20FF, 1'b1,
        4'h2, 4'h2, 4'h2, 4'h1, 1'b0, 1'b1},
      '{32'h4009_2100, 32'h4009_22FF, 1'b1,
        4'h2, 4'h2, 4'h1, 4'h1, 1'b1, 1'b1},
      '{32'h4009_3000, 32'h4009_C0FF, 1'b1,
        4'h2, 4'h2, 4'h1, 4'h1, 1'b1, 1'b1},
      '{32'h407E_0000, 32'h407F_FFFF, 1'b0,
        4'h3, 4'h3, 4'h3, 4'h3, 1'b0, 1'b0},
      '{32'hE200_0000, 32'hE680_0FFF, 1'b0,
        4'h2, 4'h2, 4'h2, 4'h2, 1'b0, 1'b0}
   };

endpackage

// ### verilog/pawd_region_decoder.sv
// Combinational address decoder: finds the region of an address and
// flags the 16-bit data registers and the port read area.
// Assumes the address is stable while it is decoded.
`timescale 1ns/10ps
module pawd_region_decoder (
   input  wire logic [pawd_pkg::ADDR_W-1:0] addr_i,
   output pawd_pkg::pawd_decode_type        dec_o
);

   function automatic logic in_range(
      input logic [pawd_pkg::ADDR_W-1:0] a,
      input logic [pawd_pkg::ADDR_W-1:0] lo,
      input logic [pawd_pkg::ADDR_W-1:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction

   logic [pawd_pkg::NREG-1:0] hits;
   logic [pawd_pkg::IDX_W-1:0] first;

   genvar g;
   generate
      for (g = 0; g < pawd_pkg::NREG; g++) begin : g_hit
         assign hits[g] = in_range(addr_i, pawd_pkg::REGIONS[g].lo,
                                   pawd_pkg::REGIONS[g].hi);
      end
   endgenerate

   // Regions never overlap, so the lowest hit is the only one.
   always_comb begin
      first = '0;
      for (int i = pawd_pkg::NREG - 1; i >= 0; i--) begin
         if (hits[i]) begin
            first = i[pawd_pkg::IDX_W-1:0];
         end
      end
   end

   assign dec_o.hit      = |hits;
   assign dec_o.idx      = first;
   assign dec_o.reg_info = pawd_pkg::REGIONS[first];
   assign dec_o.port_rd  = in_range(addr_i, pawd_pkg::PORT_RD_LO,
                                    pawd_pkg::PORT_RD_HI);
   assign dec_o.wide16   = (addr_i == pawd_pkg::SER_RX16_ADDR) ||
                           (addr_i == pawd_pkg::SER_TX16_ADDR) ||
                           (addr_i == pawd_pkg::CMP_DAT16_ADDR);

endmodule

// ### verilog/pawd_wait_decoder.sv
// Access wait generator between the bus masters and the peripheral
// register areas: holds ready low for the region's access length.
// Assumes the master drives request, address and direction on the core
// clock and keeps them stable from the request until ready.
`timescale 1ns/10ps

module pawd_wait_decoder (
   input  wire logic                         ref_clk_i,
   input  wire logic                         resetn_i,
   input  wire logic [pawd_pkg::DIV_W-1:0]   pclk_div_i,
   input  wire logic [pawd_pkg::LEN_W-1:0]   port_read_wait_count_i,
   input  wire logic                         req_i,
   input  wire logic                         write_i,
   input  wire logic                         grant_i,
   input  wire logic [pawd_pkg::ADDR_W-1:0]  addr_i,
   output logic                              ready_o,
   output logic                              busy_o,
   output logic                              peripheral_bus_clock_en_o,
   output logic                              unmapped_o,
   output logic [pawd_pkg::IDX_W-1:0]        region_o,
   output logic [pawd_pkg::CNT_W-1:0]        last_cycles_o
);

   pawd_pkg::pawd_decode_type dec;
   pawd_pkg::pawd_state_type  state;
   pawd_pkg::pawd_state_type  next_state;

   logic [pawd_pkg::DIV_W-1:0] div_cnt;
   logic [pawd_pkg::CNT_W-1:0] cnt;
   logic [pawd_pkg::CNT_W-1:0] next_cnt;
   logic [pawd_pkg::CNT_W-1:0] elapsed;
   logic                       unit_pclk;
   logic                       pclk_en;

   pawd_region_decoder u_dec (
      .addr_i (addr_i),
      .dec_o  (dec)
   );

   // Peripheral clock as an enable: one pulse every pclk_div_i+1 cycles.
   // A divide value of zero means the two clocks are equal.
   wire logic fast_core = (pclk_div_i != pawd_pkg::DIV_RESET);
   wire logic div_wrap  = (div_cnt == pawd_pkg::DIV_RESET);

   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         div_cnt <= pawd_pkg::DIV_RESET;
         pclk_en <= 1'b0;
      end else begin
         div_cnt <= div_wrap ? pclk_div_i : div_cnt - 3'h1;
         pclk_en <= div_wrap;
      end
   end

   // Length selection runs on the live address in every cycle.
   // core-clock regions ignore the clock ratio.
   wire logic [pawd_pkg::LEN_W-1:0] eq_len =
      write_i ? dec.reg_info.eq_wr : dec.reg_info.eq_rd;
   // the table holds the truncated least count.
   wire logic [pawd_pkg::LEN_W-1:0] fs_len =
      write_i ? dec.reg_info.fs_wr : dec.reg_info.fs_rd;
   wire logic sync_sel =
      write_i ? dec.reg_info.sy_wr : dec.reg_info.sy_rd;
   wire logic use_fast = dec.reg_info.pclk & fast_core;

   wire logic [pawd_pkg::LEN_W-1:0] base_len =
      !dec.hit ? pawd_pkg::UNMAPPED_LEN : (use_fast ? fs_len : eq_len);

   wire logic [pawd_pkg::LEN_W-1:0] wide_add =
      dec.wide16 ? pawd_pkg::WIDE16_EXTRA : 4'h0;

   wire logic [pawd_pkg::LEN_W-1:0] port_add =
      (dec.port_rd && !write_i) ? port_read_wait_count_i : 4'h0;

   wire logic [pawd_pkg::CNT_W-1:0] total_len =
      {4'h0, base_len} + {4'h0, wide_add} + {4'h0, port_add};

   // The taken cycle is the first cycle of a core-clock access, so ready
   // rises N-1 cycles after it. A peripheral-clock access counts whole
   // enables after the take, and the take's core cycle is not one.
   wire logic unit_now = use_fast & dec.hit;
   wire logic [pawd_pkg::CNT_W-1:0] skip_len = unit_now ? 8'h01 : 8'h02;
   wire logic [pawd_pkg::CNT_W-1:0] load_cnt =
      (total_len <= skip_len) ? 8'h00 : total_len - skip_len;

   // a faster core waits for a peripheral edge before counting when the region's sy_* bit for the direction is set.
   wire logic need_sync = use_fast & sync_sel & dec.hit;

   wire logic take = (state == pawd_pkg::ST_IDLE) & req_i & grant_i;

   // losing the bus to another master freezes the count.
   wire logic step = grant_i & (unit_pclk ? pclk_en : 1'b1);

   wire logic done = (state == pawd_pkg::ST_COUNT) &&
                     (cnt == pawd_pkg::CNT_RESET);

   always_comb begin
      next_state = state;
      next_cnt   = cnt;
      unique case (state)
         pawd_pkg::ST_IDLE: begin
            if (take) begin
               next_cnt   = load_cnt;
               next_state = need_sync ? pawd_pkg::ST_SYNC
                                      : pawd_pkg::ST_COUNT;
            end
         end
         pawd_pkg::ST_SYNC: begin
            if (grant_i && pclk_en) begin
               next_state = pawd_pkg::ST_COUNT;
            end
         end
         pawd_pkg::ST_COUNT: begin
            if (done) begin
               next_state = pawd_pkg::ST_IDLE;
            end else if (step) begin
               next_cnt = cnt - 8'h01;
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         state <= pawd_pkg::ST_IDLE;
         cnt   <= pawd_pkg::CNT_RESET;
      end else begin
         state <= next_state;
         cnt   <= next_cnt;
      end
   end

   // Access attributes are captured when the request is taken.
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         unit_pclk  <= 1'b0;
         unmapped_o <= 1'b0;
         region_o   <= '0;
      end else if (take) begin
         unit_pclk  <= use_fast & dec.hit;
         unmapped_o <= !dec.hit;
         region_o   <= dec.idx;
      end
   end

   // Measured length in core cycles. The take cycle counts as the first,
   // so the first busy cycle is the second and the ready cycle the last.
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         elapsed       <= pawd_pkg::CNT_RESET;
         last_cycles_o <= pawd_pkg::CNT_RESET;
      end else if (take) begin
         elapsed <= 8'h02;
      end else if (done) begin
         last_cycles_o <= elapsed;
      end else if (state != pawd_pkg::ST_IDLE) begin
         elapsed <= elapsed + 8'h01;
      end
   end

   // ready stays low until the loaded count has run out.
   assign ready_o = done;
   assign busy_o  = (state != pawd_pkg::ST_IDLE);
   assign peripheral_bus_clock_en_o = pclk_en;

endmodule

// ### testbench/pawd_wait_properties.sv
// Checker for the wait decoder: access lengths, handshake and logging.
// Assumes it is bound to the decoder and sees only the decoder's ports.
`timescale 1ns/10ps
module pawd_wait_properties (
   input logic                         ref_clk_i,
   input logic                         resetn_i,
   input logic [pawd_pkg::DIV_W-1:0]   pclk_div_i,
   input logic [pawd_pkg::LEN_W-1:0]   port_read_wait_count_i,
   input logic                         req_i,
   input logic                         write_i,
   input logic                         grant_i,
   input logic [pawd_pkg::ADDR_W-1:0]  addr_i,
   input logic                         ready_o,
   input logic                         busy_o,
   input logic                         peripheral_bus_clock_en_o,
   input logic                         unmapped_o,
   input logic [pawd_pkg::IDX_W-1:0]   region_o,
   input logic [pawd_pkg::CNT_W-1:0]   last_cycles_o
);
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!resetn_i);
   logic [pawd_pkg::CNT_W-1:0] cyc;
   wire take  = req_i && grant_i && !busy_o;
   wire equal = pclk_div_i == 3'h0;
   wire ctl   = addr_i >= 32'h4000_0000 && addr_i <= 32'h4001_BFFF;
   wire system_control_area  = addr_i >= 32'h4001_E000 && addr_i <= 32'h4001_EFFF;
   wire flash = addr_i >= 32'h407E_0000 && addr_i <= 32'h407F_FFFF;
   wire port  = addr_i >= 32'h4004_0000 && addr_i <= 32'h4004_1FFF;
   wire rx16  = addr_i == pawd_pkg::SER_RX16_ADDR;
   // Wall-clock cycles of the running access, stalled cycles included.
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         cyc <= 8'h00;
      end else if (take) begin
         cyc <= 8'h02;
      end else if (busy_o) begin
         cyc <= cyc + 8'h01;
      end
   end
   ready_busy_a: assert property (ready_o |-> busy_o)
      else $error("ready outside an access");
   take_busy_a: assert property (take |=> busy_o)
      else $error("taken request not busy");
   end_idle_a: assert property (ready_o |=> !busy_o)
      else $error("still busy after ready");
   stall_hold_a: assert property (!grant_i && !busy_o |=> !busy_o)
      else $error("access taken without grant");
   ctl_len_a: assert property (take && ctl ##1 grant_i |-> ready_o)
      else $error("control area length wrong");
   system_control_area_wait_a: assert property (take && system_control_area |=> !ready_o [*2])
      else $error("system area ready too early");
   system_control_area_done_a: assert property (
      take && system_control_area ##1 grant_i [*3] |-> ready_o)
      else $error("system area ready late");
   flash_len_a: assert property (
      take && flash ##1 grant_i [*2] |-> ready_o && !$past(ready_o))
      else $error("flash area length wrong");
   wide_len_a: assert property (
      take && rx16 && equal ##1 grant_i [*3] |-> ready_o && !$past(ready_o))
      else $error("wide register length wrong");
   sync_add_a: assert property (
      take && port && pclk_div_i == 3'h1 |=> !ready_o [*2])
      else $error("no synchronising cycle");
   log_len_a: assert property (ready_o |=> last_cycles_o == $past(cyc))
      else $error("logged length wrong");
   region_cap_a: assert property (take && system_control_area |=> region_o == 4'h1)
      else $error("region index wrong");
   pclk_every_a: assert property (
      equal && $past(pclk_div_i) == 3'h0 && $past(pclk_div_i, 2) == 3'h0
      && $past(resetn_i, 2) |-> peripheral_bus_clock_en_o)
      else $error("peripheral enable missing");
   cover property (take && system_control_area);
   cover property (ready_o && pclk_div_i != 3'h0);
   cover property (busy_o && !grant_i);
endmodule
bind pawd_wait_decoder pawd_wait_properties pawd_wait_properties_i (
   .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .pclk_div_i(pclk_div_i),
   .port_read_wait_count_i(port_read_wait_count_i), .req_i(req_i),
   .write_i(write_i), .grant_i(grant_i), .addr_i(addr_i),
   .ready_o(ready_o), .busy_o(busy_o), .unmapped_o(unmapped_o),
   .peripheral_bus_clock_en_o(peripheral_bus_clock_en_o),
   .region_o(region_o), .last_cycles_o(last_cycles_o));

// ### testbench/pawd_bus_master_model.sv
// Bus master model: issues one access at a time and waits for ready.
// Assumes a one-cycle ready pulse on the core clock.
`timescale 1ns/10ps
module pawd_bus_master_model (
   input  wire logic                    ref_clk_i,
   input  wire logic                    ready_i,
   output logic                         req_o,
   output logic                         write_o,
   output logic [pawd_pkg::ADDR_W-1:0]  addr_o
);
   initial begin
      req_o = 1'b0;
      write_o = 1'b0;
      addr_o = 32'h0000_0000;
   end
   task automatic access(input logic [31:0] a, input logic wr,
                         input int gap, output int cycles);
      cycles = 0;
      repeat (gap) @(negedge ref_clk_i);
      @(negedge ref_clk_i);
      req_o = 1'b1;
      write_o = wr;
      addr_o = a;
      // The request cycle counts as the first. Ready is looked at in the
      // middle of each cycle, where it is settled, and the request stands
      // through the rising edge that ends the access. Bounded for hangs.
      cycles = 1;
      while (cycles < 64) begin
         @(negedge ref_clk_i);
         cycles++;
         if (ready_i === 1'b1) break;
      end
      @(negedge ref_clk_i);
      req_o = 1'b0;
      // A released bus shows the inverse, never a stale valid address.
      write_o = ~write_o;
      addr_o = ~addr_o;
   endtask
endmodule

// ### testbench/pawd_wait_decoder_test.sv
// Self-checking bench for the wait decoder, one task per scenario.
// Assumes the master model drives request, address and direction.
`timescale 1ns/10ps
module pawd_wait_decoder_test;
   logic                         ref_clk;
   logic                         resetn;
   logic [pawd_pkg::DIV_W-1:0]   pclk_div;
   logic [pawd_pkg::LEN_W-1:0]   port_wait;
   logic                         grant;
   logic                         req;
   logic                         write;
   logic [pawd_pkg::ADDR_W-1:0]  addr;
   logic                         ready;
   logic                         busy;
   logic                         unmapped;
   logic [pawd_pkg::IDX_W-1:0]   region;
   logic [pawd_pkg::CNT_W-1:0]   last_cycles;
   int                           fail_count = 0;
   int                           tests_run = 0;
   int                           n;
   pawd_wait_decoder pawd_wait_decoder_i (.ref_clk_i(ref_clk),
      .resetn_i(resetn), .pclk_div_i(pclk_div), .req_i(req),
      .port_read_wait_count_i(port_wait), .write_i(write),
      .grant_i(grant), .addr_i(addr), .ready_o(ready), .busy_o(busy),
      .peripheral_bus_clock_en_o(), .unmapped_o(unmapped), .region_o(region),
      .last_cycles_o(last_cycles));
   pawd_bus_master_model pawd_bus_master_model_i (.ref_clk_i(ref_clk),
      .ready_i(ready), .req_o(req), .write_o(write), .addr_o(addr));
   always #25 ref_clk = ~ref_clk;
   task automatic test_done;
      $display("Checks: %0d, mismatches: %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input int lo, input int hi);
      tests_run++;
      if (^got === 1'bx || got < lo || got > hi) begin
         fail_count++;
         $display("ERROR %0t: got %0d, want %0d to %0d", $time, got, lo, hi);
      end
   endtask
   task automatic xfer(input logic [31:0] a, input logic wr,
                       input int lo, input int hi);
      pawd_bus_master_model_i.access(a, wr, 0, n);
      chk(n[7:0], lo, hi);
      if (n >= 64) test_done;
      chk(last_cycles, lo, hi);
      chk({7'h00, unmapped}, 0, 0);
   endtask
   task automatic do_reset;
      resetn = 1'b0;
      repeat (8) @(negedge ref_clk);
      chk({ready, busy, 2'h0, region}, 0, 0);
      chk(last_cycles, 0, 0);
      resetn = 1'b1;
   endtask
   task automatic t_core;
      xfer(32'h4000_0000, 1'b0, 2, 2);
      xfer(32'h4001_BFFF, 1'b1, 2, 2);
      xfer(32'h4001_E000, 1'b0, 4, 4);
      xfer(32'h4001_EFFF, 1'b1, 4, 4);
      xfer(32'h407F_FFFF, 1'b0, 3, 3);
   endtask
   task automatic t_pclk_equal;
      xfer(32'h4004_1000, 1'b0, 3, 3);
      xfer(32'h4005_FFFF, 1'b1, 3, 3);
      xfer(32'h4009_1100, 1'b0, 3, 3);
      xfer(32'h4009_22FF, 1'b1, 2, 2);
      xfer(32'h4009_3000, 1'b0, 2, 2);
      xfer(32'h4009_3000, 1'b0, 2, 2);
   endtask
   task automatic t_wide;
      xfer(pawd_pkg::SER_RX16_ADDR, 1'b0, 4, 4);
      xfer(pawd_pkg::SER_TX16_ADDR, 1'b1, 4, 4);
      xfer(pawd_pkg::CMP_DAT16_ADDR, 1'b0, 4, 4);
   endtask
   task automatic t_port_wait;
      port_wait = 4'h3;
      xfer(32'h4004_0000, 1'b0, 6, 6);
      xfer(32'h4004_0800, 1'b0, 6, 6);
      xfer(32'h4004_0000, 1'b1, 3, 3);
      port_wait = 4'h0;
   endtask
   task automatic t_faster;
      pclk_div = 3'h1;
      repeat (4) @(negedge ref_clk);
      xfer(32'h4004_1000, 1'b1, 4, 8);
      xfer(32'h4009_3000, 1'b0, 2, 6);
      xfer(32'h4001_E000, 1'b0, 4, 4);
      pclk_div = 3'h0;
      repeat (4) @(negedge ref_clk);
   endtask
   task automatic t_stall;
      grant = 1'b0;
      fork
         pawd_bus_master_model_i.access(32'h4001_E000, 1'b0, 1, n);
         begin
            repeat (4) @(negedge ref_clk);
            chk({7'h00, busy}, 0, 0);
            grant = 1'b1;
         end
      join
      chk(last_cycles, 4, 4);
      fork
         pawd_bus_master_model_i.access(32'h4001_E000, 1'b0, 0, n);
         begin
            @(negedge ref_clk);
            @(posedge ref_clk);
            @(negedge ref_clk);
            grant = 1'b0;
            repeat (2) @(negedge ref_clk);
            grant = 1'b1;
         end
      join
      chk(last_cycles, 6, 6);
   endtask
   initial begin
      ref_clk = 1'b0;
      resetn = 1'b0;
      pclk_div = 3'h0;
      port_wait = 4'h0;
      grant = 1'b1;
      do_reset;
      t_core;
      t_pclk_equal;
      t_wide;
      t_port_wait;
      t_faster;
      do_reset;
      t_stall;
      test_done;
   end
endmodule
